// File: dsls_top.v
/*
  Drive status lamp sequencer: bridge, logic supply, port link, run-state
  and error lamps, Avalon-MM register slave and one level interrupt.
  Assumes status inputs synchronous to sys_clk and lamp drivers outside.
*/
// Behaviour
// R1 - Bridge lamp green when bus powered and enabled, red on fault.
// R2 - Logic supply lamp green while the logic supply is present.
// R3 - Port lamp steady for idle link, flickers with traffic, off without link.
// R4 - Run-state lamp steady in the full run state.
// R5 - Run-state lamp blinks 200ms on, 200ms off in mailbox-only state.
// R6 - Run-state lamp single 200ms flash then 1000ms dark in inputs-only state.
// R7 - Run-state lamp flickers 50ms while booting, loading firmware or downloading.
// R8 - Run-state lamp dark in startup idle state.
// R9 - Error lamp steady red after process data interface watchdog timeout.
// R10 - Error lamp blinks 200ms on and off on configuration error.
// R11 - Error lamp flickers on boot error in idle with change flag 0x01.
// R12 - Error lamp single flash on autonomous state change with change flag 0x01.
// R13 - Error lamp double flash then 1000ms dark on application watchdog timeout.
// R14 - Station alias set by network or software; position address assigned by network.
// R15 - All patterns use one millisecond tick and restart on pattern change; the port lamp flicker runs free and does not restart.
// R16 - Error lamp shows most recently raised condition until it clears.
`timescale 1ns/100ps
`include "dsls_defs.vh"

module dsls_top #(
  parameter [15:0] TICK_CYCLES = `DSLS_TICK_CYCLES
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        dcBusPowered,
  input  wire        driveEnabled,
  input  wire        driveFault,
  input  wire        logicSupplyOk,
  input  wire [1:0]  portLinkValid,
  input  wire [1:0]  portActivity,
  input  wire [2:0]  busState,
  input  wire [7:0]  changeFlag,
  input  wire        bootError,
  input  wire        autonomousChange,
  input  wire        pdiWatchdogTimeout,
  input  wire        configError,
  input  wire        appWatchdogTimeout,
  input  wire        aliasNetLoad,
  input  wire [15:0] aliasNet,
  input  wire [15:0] positionAddress,
  input  wire [7:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWritedata,
  input  wire [3:0]  avsByteenable,
  output reg  [31:0] avsReaddata,
  output wire        avsWaitrequest,
  output reg         irq,
  output reg         bridgeLampGreen,
  output reg         bridgeLampRed,
  output reg         logicSupplyLamp,
  output reg  [1:0]  portLinkActivityLamp,
  output wire        runStateLamp,
  output wire        errorLamp,
  output reg  [15:0] stationAlias
);

  // ----------------------------------------------------------------------
  // Error condition slots
  // ----------------------------------------------------------------------
  localparam [2:0] ERR_PDI    = 3'h0;
  localparam [2:0] ERR_CONFIG = 3'h1;
  localparam [2:0] ERR_BOOT   = 3'h2;
  localparam [2:0] ERR_AUTO   = 3'h3;
  localparam [2:0] ERR_APPWD  = 3'h4;
  localparam [2:0] ERR_NONE   = 3'h7;
  // Slot order doubles as tie priority

  // ----------------------------------------------------------------------
  // Bus handshake states, one-hot
  // ----------------------------------------------------------------------
  localparam [1:0] BUS_IDLE = 2'b01;
  localparam [1:0] BUS_ACK  = 2'b10;
  // Two states cover the fixed wait state

  wire        msTick;
  reg  [1:0]  busSt;
  reg  [1:0]  next_busSt;
  reg         fwDownload;
  reg  [3:0]  irqStatus;
  reg  [3:0]  irqMask;
  reg  [9:0]  flickCount;
  reg         flickPhase;
  reg  [4:0]  errPrev;
  reg  [2:0]  errSel;
  reg  [2:0]  next_errSel;
  reg  [2:0]  runPattern;
  reg  [2:0]  errPattern;
  reg         faultPrev;
  reg  [1:0]  linkPrev;
  reg  [2:0]  statePrev;
  reg  [31:0] next_readdata;
  wire [4:0]  errActive;
  wire [4:0]  errRise;
  wire [3:0]  irqEvents;
  wire        accessDone;
  wire        regWrite;
  wire        statRead;

  // ----------------------------------------------------------------------
  // Shared time base
  // ----------------------------------------------------------------------
  // One divider keeps all lamps in step
  dsls_ms_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) uTick (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .msTick  (msTick)
  );

  // ----------------------------------------------------------------------
  // Bridge, logic supply and port lamps
  // ----------------------------------------------------------------------
  // Fault outranks enable so the lamp never shows both colours
  always @(posedge sys_clk) begin
    if (!nrst) begin
      bridgeLampGreen      <= 1'b0;
      bridgeLampRed        <= 1'b0;
      logicSupplyLamp      <= 1'b0;
      portLinkActivityLamp <= 2'b00;
    end else begin
      bridgeLampGreen      <= dcBusPowered & driveEnabled & ~driveFault; // [R1]
      bridgeLampRed        <= driveFault; // [R1]
      logicSupplyLamp      <= logicSupplyOk; // [R2]
      portLinkActivityLamp <= portLinkValid & (~portActivity | {2{flickPhase}}); // [R3]
    end
  end

  // Free-running flicker for the port lamps
  always @(posedge sys_clk) begin
    if (!nrst) begin
      flickCount <= 10'h000;
      flickPhase <= 1'b1;
    end else if (msTick) begin // [R15]
      if (flickCount + 10'h001 == `DSLS_FLICK_MS) begin
        flickCount <= 10'h000;
        flickPhase <= ~flickPhase; // [R3]
      end else begin
        flickCount <= flickCount + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Run-state lamp pattern
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      runPattern <= `DSLS_PAT_FLICKER;
    end else if (fwDownload) begin
      runPattern <= `DSLS_PAT_FLICKER; // [R7]
    end else begin
      case (busState)
        `DSLS_ST_RUN:     runPattern <= `DSLS_PAT_ON; // [R4]
        `DSLS_ST_MAILBOX: runPattern <= `DSLS_PAT_BLINK; // [R5]
        `DSLS_ST_INPUTS:  runPattern <= `DSLS_PAT_SINGLE; // [R6]
        `DSLS_ST_IDLE:    runPattern <= `DSLS_PAT_OFF; // [R8]
        `DSLS_ST_FWLOAD:  runPattern <= `DSLS_PAT_FLICKER; // [R7]
        `DSLS_ST_BOOTING: runPattern <= `DSLS_PAT_FLICKER; // [R7]
        default:          runPattern <= `DSLS_PAT_OFF;
      endcase
    end
  end

  // Generators add one cycle of lamp delay
  dsls_pattern_gen uRunLamp (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .msTick  (msTick),
    .pattern (runPattern),
    .lamp    (runStateLamp)
  );

  // ----------------------------------------------------------------------
  // Error conditions and selection
  // ----------------------------------------------------------------------
  assign errActive[ERR_PDI]    = pdiWatchdogTimeout; // [R9]
  assign errActive[ERR_CONFIG] = configError; // [R10]
  assign errActive[ERR_BOOT]   = bootError & (busState == `DSLS_ST_IDLE) &
                                 (changeFlag == `DSLS_CHANGE_ERR); // [R11]
  assign errActive[ERR_AUTO]   = autonomousChange & (changeFlag == `DSLS_CHANGE_ERR); // [R12]
  assign errActive[ERR_APPWD]  = appWatchdogTimeout; // [R13]
  // A level held high raises one event only
  assign errRise               = errActive & ~errPrev;

  // Newest rise wins; ties and fallbacks take the lowest slot
  always @* begin
    next_errSel = errSel;
    if (|errRise) begin // [R16]
      casez (errRise)
        5'b????1: next_errSel = ERR_PDI;
        5'b???10: next_errSel = ERR_CONFIG;
        5'b??100: next_errSel = ERR_BOOT;
        5'b?1000: next_errSel = ERR_AUTO;
        default:  next_errSel = ERR_APPWD;
      endcase
    end else if (errSel == ERR_NONE || !errActive[errSel]) begin // [R16]
      casez (errActive)
        5'b????1: next_errSel = ERR_PDI;
        5'b???10: next_errSel = ERR_CONFIG;
        5'b??100: next_errSel = ERR_BOOT;
        5'b?1000: next_errSel = ERR_AUTO;
        5'b10000: next_errSel = ERR_APPWD;
        default:  next_errSel = ERR_NONE;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      errPrev    <= 5'h00;
      errSel     <= ERR_NONE;
      errPattern <= `DSLS_PAT_OFF;
    end else begin
      errPrev <= errActive;
      errSel  <= next_errSel;
      case (next_errSel)
        ERR_PDI:    errPattern <= `DSLS_PAT_ON; // [R9]
        ERR_CONFIG: errPattern <= `DSLS_PAT_BLINK; // [R10]
        ERR_BOOT:   errPattern <= `DSLS_PAT_FLICKER; // [R11]
        ERR_AUTO:   errPattern <= `DSLS_PAT_SINGLE; // [R12]
        ERR_APPWD:  errPattern <= `DSLS_PAT_DOUBLE; // [R13]
        default:    errPattern <= `DSLS_PAT_OFF;
      endcase
    end
  end

  dsls_pattern_gen uErrLamp (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .msTick  (msTick),
    .pattern (errPattern),
    .lamp    (errorLamp)
  );

  // ----------------------------------------------------------------------
  // Avalon-MM handshake
  // ----------------------------------------------------------------------
  // Fixed single wait state keeps read data registered
  always @* begin
    next_busSt = busSt;
    case (busSt)
      BUS_IDLE: if (avsRead | avsWrite) next_busSt = BUS_ACK;
      BUS_ACK:  next_busSt = BUS_IDLE;
      default:  next_busSt = BUS_IDLE;
    endcase
  end

  // Wait only outside the acknowledge cycle
  assign avsWaitrequest = (avsRead | avsWrite) & ~busSt[1];
  assign accessDone     = busSt[1] & (avsRead | avsWrite);
  assign regWrite       = accessDone & avsWrite;
  assign statRead       = accessDone & avsRead & (avsAddress == `DSLS_REG_IRQ_STAT);

  always @* begin
    next_readdata = 32'h00000000;
    case (avsAddress)
      `DSLS_REG_CTRL:     next_readdata = {31'h00000000, fwDownload};
      `DSLS_REG_STATUS:   next_readdata = {16'h0000, 1'b0, errSel, 1'b0, runPattern,
                                           1'b0, errPattern, errorLamp, runStateLamp,
                                           portLinkActivityLamp};
      `DSLS_REG_IRQ_STAT: next_readdata = {28'h0000000, irqStatus};
      `DSLS_REG_IRQ_MASK: next_readdata = {28'h0000000, irqMask};
      `DSLS_REG_ALIAS:    next_readdata = {16'h0000, stationAlias};
      `DSLS_REG_POS_ADDR: next_readdata = {16'h0000, positionAddress}; // [R14]
      default:            next_readdata = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      busSt       <= BUS_IDLE;
      avsReaddata <= 32'h00000000;
    end else begin
      busSt <= next_busSt;
      if (busSt[0] & avsRead) begin
        avsReaddata <= next_readdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control, mask and alias registers
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      fwDownload   <= `DSLS_CTRL_RESET;
      irqMask      <= `DSLS_MASK_RESET;
      stationAlias <= `DSLS_ALIAS_RESET;
    end else begin
      // One-byte fields use lane 0 only
      if (regWrite && avsAddress == `DSLS_REG_CTRL && avsByteenable[0]) begin
        fwDownload <= avsWritedata[0]; // [R7]
      end
      if (regWrite && avsAddress == `DSLS_REG_IRQ_MASK && avsByteenable[0]) begin
        irqMask <= avsWritedata[3:0];
      end
      // Network load outranks a simultaneous software write
      if (aliasNetLoad) begin
        stationAlias <= aliasNet; // [R14]
      end else if (regWrite && avsAddress == `DSLS_REG_ALIAS) begin
        if (avsByteenable[0]) stationAlias[7:0]  <= avsWritedata[7:0]; // [R14]
        if (avsByteenable[1]) stationAlias[15:8] <= avsWritedata[15:8]; // [R14]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------------
  // Edges against last cycle's levels
  assign irqEvents[`DSLS_IRQ_FAULT]    = driveFault & ~faultPrev;
  assign irqEvents[`DSLS_IRQ_ERROR]    = |errRise;
  assign irqEvents[`DSLS_IRQ_LINKLOST] = |(linkPrev & ~portLinkValid);
  assign irqEvents[`DSLS_IRQ_STATECHG] = (busState != statePrev);

  // An event in the clearing read's cycle stays set
  always @(posedge sys_clk) begin
    if (!nrst) begin
      faultPrev <= 1'b0;
      linkPrev  <= 2'b00;
      statePrev <= `DSLS_ST_BOOTING;
      irqStatus <= 4'h0;
      irq       <= 1'b0;
    end else begin
      faultPrev <= driveFault;
      linkPrev  <= portLinkValid;
      statePrev <= busState;
      irqStatus <= (statRead ? 4'h0 : irqStatus) | irqEvents;
      irq       <= |(((statRead ? 4'h0 : irqStatus) | irqEvents) & irqMask);
    end
  end

endmodule

// File: dsls_defs.vh
/*
  Shared constants of the lamp sequencer: map, fields, codes, timing.
  Assumes inclusion by its bare name from every design file that needs it.
*/
`ifndef DSLS_DEFS_VH
`define DSLS_DEFS_VH

// ----------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------
`define DSLS_TICK_CYCLES   16'd40000

// ----------------------------------------------------------------------
// Lamp timing in milliseconds
// ----------------------------------------------------------------------
`define DSLS_FLASH_MS      10'd200
`define DSLS_PAUSE_MS      10'd1000
`define DSLS_FLICK_MS      10'd50

// ----------------------------------------------------------------------
// Lamp patterns
// ----------------------------------------------------------------------
`define DSLS_PAT_OFF       3'h0
`define DSLS_PAT_ON        3'h1
`define DSLS_PAT_BLINK     3'h2
`define DSLS_PAT_SINGLE    3'h3
`define DSLS_PAT_DOUBLE    3'h4
`define DSLS_PAT_FLICKER   3'h5

// ----------------------------------------------------------------------
// Fieldbus state codes
// ----------------------------------------------------------------------
`define DSLS_ST_BOOTING    3'h0
`define DSLS_ST_IDLE       3'h1
`define DSLS_ST_MAILBOX    3'h2
`define DSLS_ST_FWLOAD     3'h3
`define DSLS_ST_INPUTS     3'h4
`define DSLS_ST_RUN        3'h5
`define DSLS_CHANGE_ERR    8'h01

// ----------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------
`define DSLS_REG_CTRL      8'h00
`define DSLS_REG_STATUS    8'h04
`define DSLS_REG_IRQ_STAT  8'h08
`define DSLS_REG_IRQ_MASK  8'h0c
`define DSLS_REG_ALIAS     8'h10
`define DSLS_REG_POS_ADDR  8'h14
`define DSLS_CTRL_RESET    1'h0
`define DSLS_MASK_RESET    4'h0
`define DSLS_ALIAS_RESET   16'h0000
`define DSLS_IRQ_FAULT     0
`define DSLS_IRQ_ERROR     1
`define DSLS_IRQ_LINKLOST  2
`define DSLS_IRQ_STATECHG  3

`endif

// File: dsls_ms_tick.v
/*
  Millisecond time base: one-cycle pulse every TICK_CYCLES clocks.
  Assumes a single free-running clock and synchronous active-low reset.
*/
`timescale 1ns/100ps
`include "dsls_defs.vh"

module dsls_ms_tick #(
  parameter [15:0] TICK_CYCLES = `DSLS_TICK_CYCLES
) (
  input  wire sys_clk,
  input  wire nrst,
  output reg  msTick
);

  reg [15:0] divCount;

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      divCount <= 16'h0000;
      msTick   <= 1'b0;
    end else if (divCount == TICK_CYCLES - 16'h0001) begin
      divCount <= 16'h0000;
      msTick   <= 1'b1;
    end else begin
      divCount <= divCount + 16'h0001;
      msTick   <= 1'b0;
    end
  end

endmodule

// File: dsls_pattern_gen.v
/*
  One lamp pattern sequencer: off, on, blink, single, double, flicker.
  Assumes a one-cycle millisecond tick from the shared time base.
*/
`timescale 1ns/100ps
`include "dsls_defs.vh"

module dsls_pattern_gen (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire       msTick,
  input  wire [2:0] pattern,
  output reg        lamp
);

  reg [2:0] lastPattern;
  reg [1:0] phase;
  reg [9:0] msCount;
  reg [9:0] phaseLen;
  reg       lastPhase;
  reg       next_lamp;

  // ----------------------------------------------------------------------
  // Phase lengths
  // ----------------------------------------------------------------------
  always @* begin
    phaseLen  = `DSLS_FLASH_MS;
    lastPhase = (phase == 2'h1);
    case (pattern)
      `DSLS_PAT_SINGLE:  phaseLen = (phase == 2'h0) ? `DSLS_FLASH_MS : `DSLS_PAUSE_MS;
      `DSLS_PAT_DOUBLE: begin
        phaseLen  = (phase == 2'h3) ? `DSLS_PAUSE_MS : `DSLS_FLASH_MS;
        lastPhase = (phase == 2'h3);
      end
      `DSLS_PAT_FLICKER: phaseLen = `DSLS_FLICK_MS;
      default:           phaseLen = `DSLS_FLASH_MS;
    endcase
    case (pattern)
      `DSLS_PAT_OFF: next_lamp = 1'b0;
      `DSLS_PAT_ON:  next_lamp = 1'b1;
      default:       next_lamp = ~phase[0];
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      lastPattern <= `DSLS_PAT_OFF;
      phase       <= 2'h0;
      msCount     <= 10'h000;
      lamp        <= 1'b0;
    end else begin
      lamp <= next_lamp;
      if (pattern != lastPattern) begin // Restart from the first phase [R15]
        lastPattern <= pattern;
        phase       <= 2'h0;
        msCount     <= 10'h000;
      end else if (msTick) begin // Shared millisecond tick [R15]
        if (msCount + 10'h001 == phaseLen) begin
          msCount <= 10'h000;
          phase   <= lastPhase ? 2'h0 : phase + 2'h1;
        end else begin
          msCount <= msCount + 10'h001;
        end
      end
    end
  end

endmodule

// File: dsls_top_props.sv
/*
  Port checker of the status lamp sequencer top.
  Assumes binding to dsls_top, one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
`include "dsls_defs.vh"
// ----
// Checker
// ----
module dsls_top_props (
  input logic        sys_clk,
  input logic        nrst,
  input logic        dcBusPowered,
  input logic        driveEnabled,
  input logic        driveFault,
  input logic        logicSupplyOk,
  input logic [1:0]  portLinkValid,
  input logic [1:0]  portActivity,
  input logic [2:0]  busState,
  input logic        anyErrIn,
  input logic        aliasNetLoad,
  input logic [15:0] aliasNet,
  input logic        avsRead,
  input logic        avsWrite,
  input logic        avsWaitrequest,
  input logic [31:0] avsReaddata,
  input logic        bridgeLampGreen,
  input logic        bridgeLampRed,
  input logic        logicSupplyLamp,
  input logic [1:0]  portLinkActivityLamp,
  input logic        runStateLamp,
  input logic        errorLamp,
  input logic [15:0] stationAlias
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence reqNew;
    (avsRead || avsWrite) && !$past(avsRead || avsWrite);
  endsequence
  sequence oneWait;
    avsWaitrequest ##1 !avsWaitrequest;
  endsequence
  bridge_red_a: assert property (driveFault |=> bridgeLampRed)
    else $error("bridge lamp not red on fault");
  bridge_green_a: assert property (dcBusPowered && driveEnabled && !driveFault
    |=> bridgeLampGreen && !bridgeLampRed) else $error("bridge lamp not green");
  logic_lamp_a: assert property (1 |=> logicSupplyLamp == $past(logicSupplyOk))
    else $error("logic supply lamp wrong");
  port_off_a: assert property (!portLinkValid[1] |=> !portLinkActivityLamp[1])
    else $error("port lamp lit without link");
  port_steady_a: assert property (portLinkValid[0] && !portActivity[0]
    |=> portLinkActivityLamp[0]) else $error("port lamp dark on idle link");
  wait_state_a: assert property (reqNew |-> oneWait)
    else $error("bus answer not after one wait state");
  rdata_hold_a: assert property (!(avsRead && avsWaitrequest) |=> $stable(avsReaddata))
    else $error("read data moved without read");
  run_steady_a: assert property ((busState == `DSLS_ST_RUN)[*5] |-> runStateLamp)
    else $error("run lamp dark in full run state");
  err_dark_a: assert property ((!anyErrIn)[*5] |-> !errorLamp)
    else $error("error lamp lit without condition");
  alias_load_a: assert property (aliasNetLoad |=> stationAlias == $past(aliasNet))
    else $error("alias not loaded from network");
endmodule
bind dsls_top dsls_top_props i_props (.*, .anyErrIn(pdiWatchdogTimeout | configError
  | appWatchdogTimeout | bootError | autonomousChange));

// File: dsls_lamp_panel.sv
/*
  Front-panel lamp model: measures the last lit and dark spans of a lamp.
  Assumes the lamp changes only at rising edges of sys_clk.
*/
`timescale 1ns/100ps
module dsls_lamp_panel (
  input  logic        sys_clk,
  input  logic        lamp,
  output logic [15:0] lastOn,
  output logic [15:0] lastOff,
  output logic [15:0] prevOff
);
  logic        seenLamp = 1'b0;
  logic [15:0] runLen   = 16'h0000;
  // Spans in clocks; two dark spans kept for the double flash
  always @(posedge sys_clk) begin
    if (lamp === seenLamp) begin
      runLen <= runLen + 16'h0001;
    end else begin
      if (seenLamp) begin
        lastOn <= runLen;
      end else begin
        prevOff <= lastOff;
        lastOff <= runLen;
      end
      runLen <= 16'h0001;
    end
    seenLamp <= lamp;
  end
endmodule

// File: test_drive_status_lamp_sequencer.sv
/*
  Self-checking bench of the status lamp sequencer.
  Assumes dsls_top, the lamp panel model and the bound checker.
*/
`timescale 1ns/100ps
`include "dsls_defs.vh"
module test_drive_status_lamp_sequencer;
  // Short tick keeps the 1000 ms pause at 4000 clocks
  localparam [15:0] TICK = 16'h0004;
  localparam [15:0] FL   = TICK * `DSLS_FLASH_MS;
  localparam [15:0] PA   = TICK * `DSLS_PAUSE_MS;
  localparam [15:0] FK   = TICK * `DSLS_FLICK_MS;
  localparam [15:0] POS  = 16'h5a3c;
  logic        sys_clk, nrst, dcBusPowered, driveEnabled, driveFault, logicSupplyOk;
  logic        bootError, autonomousChange, pdiWatchdogTimeout, configError;
  logic        appWatchdogTimeout, aliasNetLoad, avsRead, avsWrite;
  logic [1:0]  portLinkValid, portActivity;
  logic [2:0]  busState;
  logic [7:0]  changeFlag, avsAddress;
  logic [15:0] aliasNet;
  logic [31:0] avsWritedata, rd;
  wire         avsWaitrequest, irq, bridgeLampGreen, bridgeLampRed, logicSupplyLamp;
  wire         runStateLamp, errorLamp;
  wire  [1:0]  portLinkActivityLamp;
  wire  [15:0] stationAlias, runOn, runOff, runPrev, errOn, errOff, errPrev;
  wire  [31:0] avsReaddata;
  int          failures, n_checks;
  dsls_top #(.TICK_CYCLES(TICK)) i_dut (.*, .positionAddress(POS), .avsByteenable(4'hf));
  dsls_lamp_panel i_runPanel (.sys_clk(sys_clk), .lamp(runStateLamp), .lastOn(runOn),
    .lastOff(runOff), .prevOff(runPrev));
  dsls_lamp_panel i_errPanel (.sys_clk(sys_clk), .lamp(errorLamp), .lastOn(errOn),
    .lastOff(errOff), .prevOff(errPrev));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----
  // Helpers
  // ----
  task chk(input [31:0] seen, input [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h, wanted %h", $time, seen, exp);
    end
  endtask
  task look(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task goSt(input [2:0] s);
    @(posedge sys_clk);
    busState <= s;
  endtask
  // Sampled mid-cycle: inputs only move at rising edges
  task avs(input logic wr, input [7:0] a, input [31:0] d);
    int n;
    logic w;
    n = 0;
    w = 1'b1;
    @(posedge sys_clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    while (w !== 1'b0 && n < 50) begin
      @(negedge sys_clk);
      w = avsWaitrequest;
      rd = avsReaddata;
      n++;
      @(posedge sys_clk);
    end
    if (w !== 1'b0) failures++;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task rdchk(input [7:0] a, input [31:0] e);
    avs(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task meas(input logic err, input int w, input [15:0] on, input [15:0] offSum);
    look(w);
    chk(err ? errOn : runOn, on);
    chk(err ? errOff + errPrev : runOff + runPrev, offSum);
  endtask
  // ----
  // Scenarios
  // ----
  task t_regs;
    rdchk(`DSLS_REG_CTRL, 32'h0);
    rdchk(`DSLS_REG_IRQ_MASK, 32'h0);
    rdchk(`DSLS_REG_ALIAS, 32'h0);
    avs(1'b1, `DSLS_REG_POS_ADDR, 32'hffff);
    rdchk(`DSLS_REG_POS_ADDR, {16'h0, POS});
    avs(1'b1, 8'h20, 32'h5555);
    rdchk(8'h20, 32'h0);
    avs(1'b1, `DSLS_REG_ALIAS, 32'h1234);
    rdchk(`DSLS_REG_ALIAS, 32'h1234);
    @(posedge sys_clk);
    aliasNet <= 16'habcd;
    aliasNetLoad <= 1'b1;
    @(posedge sys_clk);
    aliasNetLoad <= 1'b0;
    look(1);
    chk(stationAlias, 16'habcd);
  endtask
  task t_simple;
    int t;
    logic p;
    t = 0;
    @(posedge sys_clk);
    {dcBusPowered, driveEnabled, logicSupplyOk} <= 3'h7;
    portLinkValid <= 2'h3;
    look(2);
    chk(bridgeLampGreen, 1'b1);
    chk(logicSupplyLamp, 1'b1);
    chk(portLinkActivityLamp, 2'h3);
    @(posedge sys_clk);
    logicSupplyOk <= 1'b0;
    portLinkValid <= 2'h1;
    portActivity <= 2'h1;
    look(2);
    chk(logicSupplyLamp, 1'b0);
    chk(portLinkActivityLamp[1], 1'b0);
    p = portLinkActivityLamp[0];
    repeat (1000) begin
      @(negedge sys_clk);
      if (portLinkActivityLamp[0] !== p) t++;
      p = portLinkActivityLamp[0];
    end
    chk(t >= 4, 1'b1);
  endtask
  task t_irq;
    avs(1'b0, `DSLS_REG_IRQ_STAT, 32'h0);
    @(posedge sys_clk);
    driveFault <= 1'b1;
    look(2);
    chk(bridgeLampRed, 1'b1);
    chk(irq, 1'b0);
    rdchk(`DSLS_REG_IRQ_STAT, 32'h1);
    @(posedge sys_clk);
    driveFault <= 1'b0;
    avs(1'b1, `DSLS_REG_IRQ_MASK, 32'h1);
    @(posedge sys_clk);
    driveFault <= 1'b1;
    look(2);
    chk(irq, 1'b1);
    rdchk(`DSLS_REG_IRQ_STAT, 32'h1);
    look(1);
    chk(irq, 1'b0);
    @(posedge sys_clk);
    driveFault <= 1'b0;
  endtask
  task t_run;
    goSt(`DSLS_ST_MAILBOX);
    meas(1'b0, 4 * FL + 100, FL, 2 * FL);
    avs(1'b0, `DSLS_REG_STATUS, 32'h0);
    chk(rd[10:8], `DSLS_PAT_BLINK);
    goSt(`DSLS_ST_INPUTS);
    meas(1'b0, 2 * (FL + PA) + 100, FL, 2 * PA);
    goSt(`DSLS_ST_BOOTING);
    meas(1'b0, 4 * FK + 100, FK, 2 * FK);
    goSt(`DSLS_ST_FWLOAD);
    meas(1'b0, 4 * FK + 100, FK, 2 * FK);
    goSt(`DSLS_ST_RUN);
    look(900);
    chk(runStateLamp, 1'b1);
    goSt(`DSLS_ST_IDLE);
    look(900);
    chk(runStateLamp, 1'b0);
    avs(1'b1, `DSLS_REG_CTRL, 32'h1);
    meas(1'b0, 4 * FK + 100, FK, 2 * FK);
    avs(1'b1, `DSLS_REG_CTRL, 32'h0);
    look(10);
    chk(runStateLamp, 1'b0);
  endtask
  task t_err;
    @(posedge sys_clk);
    pdiWatchdogTimeout <= 1'b1;
    look(900);
    chk(errorLamp, 1'b1);
    @(posedge sys_clk);
    configError <= 1'b1;
    meas(1'b1, 4 * FL + 100, FL, 2 * FL);
    @(posedge sys_clk);
    configError <= 1'b0;
    look(900);
    chk(errorLamp, 1'b1);
    @(posedge sys_clk);
    pdiWatchdogTimeout <= 1'b0;
    changeFlag <= `DSLS_CHANGE_ERR;
    bootError <= 1'b1;
    meas(1'b1, 4 * FK + 100, FK, 2 * FK);
    @(posedge sys_clk);
    bootError <= 1'b0;
    autonomousChange <= 1'b1;
    busState <= `DSLS_ST_INPUTS;
    meas(1'b1, 2 * (FL + PA) + 100, FL, 2 * PA);
    @(posedge sys_clk);
    autonomousChange <= 1'b0;
    changeFlag <= 8'h00;
    appWatchdogTimeout <= 1'b1;
    meas(1'b1, 2 * (3 * FL + PA) + 100, FL, FL + PA);
    @(posedge sys_clk);
    appWatchdogTimeout <= 1'b0;
    look(10);
    chk(errorLamp, 1'b0);
  endtask
  task conclude;
    $display("failures %0d n_checks %0d", failures, n_checks);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {nrst, dcBusPowered, driveEnabled, driveFault, logicSupplyOk, bootError} = 6'h0;
    {autonomousChange, pdiWatchdogTimeout, configError, appWatchdogTimeout} = 4'h0;
    {aliasNetLoad, avsRead, avsWrite, portLinkValid, portActivity} = 7'h0;
    busState = `DSLS_ST_IDLE;
    changeFlag = 8'h00;
    avsAddress = 8'h00;
    aliasNet = 16'h0000;
    avsWritedata = 32'h0;
    failures = 0;
    n_checks = 0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_simple;
    t_irq;
    t_run;
    t_err;
    conclude;
  end
  // Whole run is about 47000 clocks
  initial begin
    #2250000;
    failures++;
    conclude;
  end
endmodule
